// >>> design/asc_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the serial channel block.
// Assumes: Byte-wide registers on a 12-bit register port.
// Notes:   Definitions only.
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
`define ASC_CH0_CTL1        12'h01a
`define ASC_CH0_CTL2        12'h01b
`define ASC_CH0_DIV         12'h01c
`define ASC_CH0_STAT        12'h01d
`define ASC_CH0_DATA        12'h01e
`define ASC_CH1_CTL1        12'hf54
`define ASC_CH1_CTL2        12'hf55
`define ASC_CH1_DIV         12'hf56
`define ASC_CH1_STAT        12'hf57
`define ASC_CH1_DATA        12'hf58
`define ASC_PWR_GATE        12'hf75
`define ASC_IRQ_STAT        12'hf76
`define ASC_IRQ_MASK        12'hf77
`define ASC_LP_CTRL         12'hf78
`define ASC_CTL1_TXE        7
`define ASC_CTL1_RXE        6
`define ASC_CTL1_STOPT      5
`define ASC_CTL1_EVEN       4
`define ASC_CTL1_PAR        3
`define ASC_CTL1_IR         2
`define ASC_CTL1_BCS        1
`define ASC_CTL1_PROT_MASK  8'h3e
`define ASC_CTL1_WMASK      8'hfe
`define ASC_CTL2_STOPR      0
`define ASC_CTL2_WMASK      8'h3f
`define ASC_CTL1_RST        8'h00
`define ASC_CTL2_RST        8'h00
`define ASC_DIV_RST         8'h00
`define ASC_GATE_RST        8'h00
`define ASC_OVERSAMPLE      8'h10
`define ASC_IR_PULSE        8'h03
`endif

// >>> design/asc_pkg.sv
// Purpose: Types of the serial channel block.
// Assumes: Nothing.
// Notes:   Constants live in the header.
package asc_pkg;
	typedef enum logic [2:0] {
		ASC_IDLE  = 3'b000,
		ASC_START = 3'b001,
		ASC_DATA  = 3'b011,
		ASC_PAR   = 3'b010,
		ASC_STOP  = 3'b110
	} asc_state_t;
endpackage : asc_pkg

// >>> design/asc_channel.sv
// Purpose: One serial channel: control registers, transmitter and receiver.
// Assumes: Inputs synchronous to i_clk; bit tick from a divider.
// Notes:   Instantiated twice by the top.
`timescale 1ns/100ps
`default_nettype none
`include "asc_regs.svh"
module asc_channel (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_gate,
	input  wire logic        i_lowpower,
	input  wire logic        i_timer_tick,
	input  wire logic [2:0]  i_sel,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_serial_in,
	output logic      [7:0]  o_rdata,
	output logic             o_serial_out,
	output logic             o_tx_event,
	output logic             o_rx_event
);
	import asc_pkg::*;

	logic [7:0]  ctl1_ff;
	logic [7:0]  ctl2_ff;
	logic [7:0]  div_ff;
	logic [7:0]  txbuf_ff;
	logic        tx_buffer_full_flag_ff;
	logic [7:0]  rxbuf_ff;
	logic        rxfull_ff;
	logic        perr_ff;
	logic        ferr_ff;
	logic        oerr_ff;
	logic [7:0]  divcnt_ff;
	logic [7:0]  tx_os_ff;
	logic [7:0]  rx_os_ff;
	asc_state_t  tx_st_ff;
	asc_state_t  rx_st_ff;
	logic [8:0]  tx_sh_ff;
	logic [3:0]  tx_cnt_ff;
	logic        tx_par_ff;
	logic [7:0]  rx_sh_ff;
	logic [3:0]  rx_cnt_ff;
	logic        rx_par_ff;
	logic        txd_ff;
	logic        tx_event_ff;
	logic        rx_event_ff;

	wire transmit_enable_bit = ctl1_ff[`ASC_CTL1_TXE];
	wire receive_enable_bit  = ctl1_ff[`ASC_CTL1_RXE];
	wire tx_stop_length      = ctl1_ff[`ASC_CTL1_STOPT];
	wire parity_even         = ctl1_ff[`ASC_CTL1_EVEN];
	wire parity_append       = ctl1_ff[`ASC_CTL1_PAR];
	wire infrared_output_select = ctl1_ff[`ASC_CTL1_IR];
	wire base_clock_select   = ctl1_ff[`ASC_CTL1_BCS];
	wire rx_stop_length      = ctl2_ff[`ASC_CTL2_STOPR];
	wire tx_busy  = (tx_st_ff != ASC_IDLE);
	wire rx_busy  = (rx_st_ff != ASC_IDLE);
	wire running  = tx_busy | rx_busy | transmit_enable_bit | receive_enable_bit;
	wire active   = i_gate & ~i_lowpower;
	// Timer source has no phase relation to the divider, so a start bit may lose one divided period.
	wire base_tick = base_clock_select ? i_timer_tick : 1'b1;
	wire div_wrap  = base_tick & (divcnt_ff == div_ff);
	wire bit_timing_clock = active & div_wrap;
	wire tx_bit   = bit_timing_clock & (tx_os_ff == `ASC_OVERSAMPLE - 8'h01);
	wire rx_mid   = bit_timing_clock & (rx_os_ff == (`ASC_OVERSAMPLE >> 1));
	wire wr_ctl1  = i_wr & (i_sel == 3'h0);
	wire wr_ctl2  = i_wr & (i_sel == 3'h1);
	wire wr_div   = i_wr & (i_sel == 3'h2);
	wire wr_data  = i_wr & (i_sel == 3'h4);
	wire rd_data  = i_rd & (i_sel == 3'h4);
	// Protected fields keep their value while the channel runs.
	wire [7:0] ctl1_keep = running ? `ASC_CTL1_PROT_MASK : 8'h00;
	wire [7:0] ctl1_wr   = ((i_wdata & ~ctl1_keep) | (ctl1_ff & ctl1_keep)) & `ASC_CTL1_WMASK;
	wire [7:0] nxt_ctl1  = i_lowpower ? (ctl1_ff & 8'h3e) : (wr_ctl1 ? ctl1_wr : ctl1_ff);
	wire [7:0] stat_word = {perr_ff, ferr_ff, oerr_ff, 1'b0, rx_busy, rxfull_ff, tx_busy, tx_buffer_full_flag_ff};
	wire       tx_par_bit = tx_par_ff ^ ~parity_even;
	wire       ir_out     = ~(txd_ff == 1'b0 && tx_os_ff < `ASC_IR_PULSE);

	always_comb begin
		case (i_sel)
			3'h0: o_rdata = ctl1_ff;
			3'h1: o_rdata = ctl2_ff;
			3'h2: o_rdata = div_ff;
			3'h3: o_rdata = stat_word;
			3'h4: o_rdata = rxbuf_ff;
			default: o_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctl1_ff   <= `ASC_CTL1_RST;
			ctl2_ff   <= `ASC_CTL2_RST;
			div_ff    <= `ASC_DIV_RST;
			divcnt_ff <= 8'h00;
		end else begin
			ctl1_ff <= nxt_ctl1;
			if (wr_ctl2 && !running) ctl2_ff <= i_wdata & `ASC_CTL2_WMASK;
			if (wr_div) div_ff <= i_wdata;
			if (!active || div_wrap) divcnt_ff <= 8'h00;
			else if (base_tick) divcnt_ff <= divcnt_ff + 8'h01;
		end
	end

	// Transmitter.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tx_st_ff <= ASC_IDLE;
			tx_os_ff <= 8'h00;
			tx_sh_ff <= 9'h000;
			tx_cnt_ff <= 4'h0;
			tx_par_ff <= 1'b0;
			txd_ff <= 1'b1;
			txbuf_ff <= 8'h00;
			tx_buffer_full_flag_ff <= 1'b0;
			tx_event_ff <= 1'b0;
		end else begin
			tx_event_ff <= 1'b0;
			if (wr_data) begin
				txbuf_ff <= i_wdata;
				tx_buffer_full_flag_ff <= 1'b1;
			end
			if (i_lowpower || !i_gate) begin
				tx_st_ff <= ASC_IDLE;
				txd_ff <= 1'b1;
				tx_buffer_full_flag_ff <= 1'b0;
			end else if (!transmit_enable_bit && tx_buffer_full_flag_ff && !wr_data) begin
				tx_buffer_full_flag_ff <= 1'b0;
			end
			if (active) begin
				if (bit_timing_clock) tx_os_ff <= tx_bit ? 8'h00 : tx_os_ff + 8'h01;
				case (tx_st_ff)
					ASC_IDLE: begin
						if (transmit_enable_bit && tx_buffer_full_flag_ff && tx_bit) begin
							tx_st_ff <= ASC_DATA;
							txd_ff <= 1'b0;
							tx_sh_ff <= {1'b1, txbuf_ff};
							tx_par_ff <= 1'b0;
							tx_cnt_ff <= 4'h0;
							tx_buffer_full_flag_ff <= wr_data;
							tx_event_ff <= 1'b1;
						end
					end
					ASC_DATA: if (tx_bit) begin
						txd_ff <= tx_sh_ff[0];
						tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
						tx_sh_ff <= {1'b1, tx_sh_ff[8:1]};
						tx_cnt_ff <= tx_cnt_ff + 4'h1;
						if (tx_cnt_ff == 4'h7) begin
							tx_st_ff <= parity_append ? ASC_PAR : ASC_STOP;
							tx_cnt_ff <= 4'h0;
						end
					end
					ASC_PAR: if (tx_bit) begin
						txd_ff <= tx_par_bit ^ tx_sh_ff[0] ^ 1'b1;
						tx_st_ff <= ASC_STOP;
						tx_cnt_ff <= 4'h0;
					end
					ASC_STOP: if (tx_bit) begin
						txd_ff <= 1'b1;
						tx_cnt_ff <= tx_cnt_ff + 4'h1;
						// A cleared enable does not stop the frame: it still ends here, and IDLE then starts no new one.
						if (tx_cnt_ff >= {3'h0, tx_stop_length}) tx_st_ff <= ASC_IDLE;
					end
					default: tx_st_ff <= ASC_IDLE;
				endcase
			end
		end
	end

	// Receiver.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rx_st_ff <= ASC_IDLE;
			rx_os_ff <= 8'h00;
			rx_sh_ff <= 8'h00;
			rx_cnt_ff <= 4'h0;
			rx_par_ff <= 1'b0;
			rxbuf_ff <= 8'h00;
			rxfull_ff <= 1'b0;
			perr_ff <= 1'b0;
			ferr_ff <= 1'b0;
			oerr_ff <= 1'b0;
			rx_event_ff <= 1'b0;
		end else begin
			rx_event_ff <= 1'b0;
			if (rd_data) begin
				rxfull_ff <= 1'b0;
				perr_ff <= 1'b0;
				ferr_ff <= 1'b0;
				oerr_ff <= 1'b0;
			end
			if (i_lowpower || !i_gate) begin
				rx_st_ff <= ASC_IDLE;
				rxfull_ff <= 1'b0;
				perr_ff <= 1'b0;
				ferr_ff <= 1'b0;
				oerr_ff <= 1'b0;
			end else if (bit_timing_clock) begin
				rx_os_ff <= (rx_os_ff == `ASC_OVERSAMPLE - 8'h01) ? 8'h00 : rx_os_ff + 8'h01;
				case (rx_st_ff)
					ASC_IDLE: if (receive_enable_bit && !i_serial_in) begin
						rx_st_ff <= ASC_START;
						rx_os_ff <= 8'h00;
					end
					ASC_START: if (rx_mid) begin
						rx_st_ff <= i_serial_in ? ASC_IDLE : ASC_DATA;
						rx_cnt_ff <= 4'h0;
						rx_par_ff <= 1'b0;
					end
					ASC_DATA: if (rx_mid) begin
						rx_sh_ff <= {i_serial_in, rx_sh_ff[7:1]};
						rx_par_ff <= rx_par_ff ^ i_serial_in;
						rx_cnt_ff <= rx_cnt_ff + 4'h1;
						if (rx_cnt_ff == 4'h7) begin
							rx_st_ff <= parity_append ? ASC_PAR : ASC_STOP;
							rx_cnt_ff <= 4'h0;
						end
					end
					ASC_PAR: if (rx_mid) begin
						perr_ff <= (rx_par_ff ^ i_serial_in) != ~parity_even;
						rx_st_ff <= ASC_STOP;
					end
					ASC_STOP: if (rx_mid) begin
						rx_cnt_ff <= rx_cnt_ff + 4'h1;
						// The first of two stop bits is skipped for framing.
						if (rx_cnt_ff >= {3'h0, rx_stop_length}) begin
							ferr_ff <= ~i_serial_in;
							oerr_ff <= rxfull_ff & ~rd_data;
							rxbuf_ff <= rx_sh_ff;
							rxfull_ff <= 1'b1;
							rx_event_ff <= 1'b1;
							rx_st_ff <= ASC_IDLE;
						end
					end
					default: rx_st_ff <= ASC_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) o_serial_out <= 1'b1;
		else o_serial_out <= infrared_output_select ? ir_out : txd_ff;
	end

	assign o_tx_event = tx_event_ff;
	assign o_rx_event = rx_event_ff;
endmodule : asc_channel
`default_nettype wire

// >>> design/asc_top.sv
// Purpose: Two-channel asynchronous serial block with register port and interrupt.
// Assumes: 10 MHz i_clk; register port answers a read one cycle later.
// Notes:   Each channel owns an identical register set at its own addresses.
//
// Overview of operation
// - Two identical channels, own pins, own addresses.
// - Data address: read receive, write transmit.
// - Gate register bits enable channels, reset zero.
// - Cleared enable stops after current frame.
// - Transmit disable discards the waiting byte.
// - Parity and clock settings shared both directions.
// - Timer clock is asynchronous, start may shorten.
// - Format fields ignore writes while operating.
// - Low power clears enables, keeps other bits.
// - Output select: plain or infrared encoded.
// - Transmit stop length one or two bits.
// - Clock select: gear clock or timer.
// - Receive stop length; first of two stops unchecked.
// - Buffer full sets on write, clears at interrupt.
`timescale 1ns/100ps
`default_nettype none
`include "asc_regs.svh"
module asc_top (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [11:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic        i_timer_output_source,
	input  wire logic        i_chan0_serial_in,
	input  wire logic        i_chan1_serial_in,
	output logic      [7:0]  o_rdata,
	output logic             o_chan0_serial_out,
	output logic             o_chan1_serial_out,
	output logic             o_irq
);
	import asc_pkg::*;

	logic [7:0] gate_ff;
	logic [3:0] irq_stat_ff;
	logic [3:0] irq_mask_ff;
	logic       lp_ff;
	logic [7:0] rdata_ff;
	logic       irq_ff;
	logic [7:0] ch_rdata [2];
	logic [1:0] ch_out;
	logic [1:0] tx_ev;
	logic [1:0] rx_ev;

	function automatic logic [2:0] chan_sel(input logic [11:0] a, input logic [11:0] base);
		chan_sel = 3'(a - base);
	endfunction

	function automatic logic chan_hit(input logic [11:0] a, input logic [11:0] base);
		chan_hit = (a >= base) && (a <= base + 12'h004);
	endfunction

	wire [11:0] base0 = `ASC_CH0_CTL1;
	wire [11:0] base1 = `ASC_CH1_CTL1;
	wire        hit0 = chan_hit(i_addr, base0);
	wire        hit1 = chan_hit(i_addr, base1);
	wire [1:0]  hits = {hit1, hit0};
	wire [2:0]  sel0 = chan_sel(i_addr, base0);
	wire [2:0]  sel1 = chan_sel(i_addr, base1);
	wire [1:0]  ch_in = {i_chan1_serial_in, i_chan0_serial_in};
	wire [3:0]  events = {rx_ev, tx_ev};
	wire        wr_gate = i_wr & (i_addr == `ASC_PWR_GATE);
	wire        wr_stat = i_wr & (i_addr == `ASC_IRQ_STAT);
	wire        wr_mask = i_wr & (i_addr == `ASC_IRQ_MASK);
	wire        wr_lp   = i_wr & (i_addr == `ASC_LP_CTRL);
	wire [3:0]  nxt_irq_stat = events | (irq_stat_ff & ~(wr_stat ? i_wdata[3:0] : 4'h0));
	wire [7:0]  nxt_rdata = hit0 ? ch_rdata[0] :
	                        hit1 ? ch_rdata[1] :
	                        (i_addr == `ASC_PWR_GATE) ? gate_ff :
	                        (i_addr == `ASC_IRQ_STAT) ? {4'h0, irq_stat_ff} :
	                        (i_addr == `ASC_IRQ_MASK) ? {4'h0, irq_mask_ff} :
	                        (i_addr == `ASC_LP_CTRL) ? {7'h00, lp_ff} : 8'h00;

	// One channel per generate pass keeps both sets identical.
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_chan
			asc_channel u_chan (
				.i_clk        (i_clk),
				.i_sys_rst    (i_sys_rst),
				.i_gate       (gate_ff[g]),
				.i_lowpower   (lp_ff),
				.i_timer_tick (i_timer_output_source),
				.i_sel        (g == 0 ? sel0 : sel1),
				.i_wr         (i_wr & hits[g]),
				.i_rd         (i_rd & hits[g]),
				.i_wdata      (i_wdata),
				.i_serial_in  (ch_in[g]),
				.o_rdata      (ch_rdata[g]),
				.o_serial_out (ch_out[g]),
				.o_tx_event   (tx_ev[g]),
				.o_rx_event   (rx_ev[g])
			);
		end
	endgenerate

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			gate_ff     <= `ASC_GATE_RST;
			irq_stat_ff <= 4'h0;
			irq_mask_ff <= 4'h0;
			lp_ff       <= 1'b0;
			rdata_ff    <= 8'h00;
			irq_ff      <= 1'b0;
		end else begin
			if (wr_gate) gate_ff <= i_wdata;
			if (wr_mask) irq_mask_ff <= i_wdata[3:0];
			if (wr_lp) lp_ff <= i_wdata[0];
			// New events win over a same-cycle clear.
			irq_stat_ff <= nxt_irq_stat;
			rdata_ff    <= i_rd ? nxt_rdata : 8'h00;
			irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
		end
	end

	assign o_rdata            = rdata_ff;
	assign o_irq              = irq_ff;
	assign o_chan0_serial_out = ch_out[0];
	assign o_chan1_serial_out = ch_out[1];
endmodule : asc_top
`default_nettype wire

// >>> tb/asc_top_props.sv
// Purpose: Port checker of the two-channel serial block.
// Assumes: Strobes stay low while reset is held.
// Notes:   Shadows of a few written registers let reads be judged.
`timescale 1ns/100ps
`default_nettype none
`include "asc_regs.svh"
module asc_top_props (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [11:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [7:0]  o_rdata,
	input  wire logic        o_chan0_serial_out,
	input  wire logic        o_irq
);
	// ****************************************
	// Shadows and line run counter
	// ****************************************
	logic [1:0] gate_ff;
	logic       lp_ff;
	logic [7:0] mask_ff;
	logic [7:0] hi_ff;
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			gate_ff <= 2'h0;
			lp_ff   <= 1'b0;
			mask_ff <= 8'h00;
		end else if (i_wr) begin
			gate_ff <= (i_addr == `ASC_PWR_GATE) ? i_wdata[1:0] : gate_ff;
			lp_ff   <= (i_addr == `ASC_LP_CTRL) ? i_wdata[0] : lp_ff;
			mask_ff <= (i_addr == `ASC_IRQ_MASK) ? i_wdata : mask_ff;
		end
	end
	// The idle line counts as long high so the first frame is not judged short.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			hi_ff <= 8'hff;
		end else begin
			hi_ff <= !o_chan0_serial_out ? 8'h00 : (hi_ff == 8'hff) ? hi_ff : hi_ff + 8'h01;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside the answer cycle");
	AST_UNMAPPED: assert property ($past(i_rd) && $past(i_addr) == 12'h100 |-> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RSV_ZERO: assert property ($past(i_rd) && ($past(i_addr) == `ASC_CH0_CTL1
		|| $past(i_addr) == `ASC_CH1_CTL1) |-> o_rdata[0] == 1'b0) else $error("reserved bit set");
	AST_GATE_RB: assert property ($past(i_rd) && $past(i_addr) == `ASC_PWR_GATE |-> o_rdata[1:0] == gate_ff)
		else $error("gate bits wrong");
	AST_LP_CLR: assert property ($past(i_rd) && $past(i_addr) == `ASC_CH0_CTL1 && lp_ff |-> o_rdata[7:6] == 2'h0)
		else $error("enables kept in low power");
	AST_MASK_OFF: assert property (mask_ff == 8'h00 |=> !o_irq)
		else $error("interrupt with all masked");
	AST_HI_RUN: assert property ($fell(o_chan0_serial_out) |-> hi_ff >= 8'h08)
		else $error("high run before fall too short");
	AST_LO_RUN: assert property ($fell(o_chan0_serial_out) |-> !o_chan0_serial_out [*3])
		else $error("low pulse too short");
	COV_TX: cover property ($fell(o_chan0_serial_out));
	COV_IRQ: cover property ($rose(o_irq));
	COV_LP: cover property (i_wr && i_addr == `ASC_LP_CTRL && i_wdata[0]);
endmodule : asc_top_props
bind asc_top asc_top_props u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_chan0_serial_out(o_chan0_serial_out), .o_irq(o_irq));
`default_nettype wire

// >>> tb/asc_far_end.sv
// Purpose: Remote serial device on one channel's lines.
// Assumes: Sixteen clocks a bit on both directions.
// Notes:   Sends frames on request and decodes every frame it sees.
`timescale 1ns/100ps
`default_nettype none
module asc_far_end #(parameter int BIT = 16) (
	input  wire logic       i_clk,
	input  wire logic       i_line,
	input  wire logic       i_par_en,
	output logic            o_line,
	output logic [7:0]      o_byte,
	output logic            o_par,
	output int              o_count
);
	initial begin
		o_line  = 1'b1;
		o_count = 0;
	end
	// Sampling mid bit tolerates a start bit shortened by one base period.
	always begin
		@(negedge i_line);
		repeat (BIT / 2) @(posedge i_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge i_clk);
			o_byte[i] = i_line;
		end
		if (i_par_en) begin
			repeat (BIT) @(posedge i_clk);
			o_par = i_line;
		end
		repeat (BIT) @(posedge i_clk);
		o_count++;
	end
	// The line returns high after the frame, its pull-up level.
	task automatic send(input logic [7:0] b, input logic par);
		logic [10:0] f;
		f = {1'b1, par ? ^b : 1'b1, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge i_clk);
			o_line <= f[i];
			repeat (BIT - 1) @(posedge i_clk);
		end
		@(posedge i_clk);
		o_line <= 1'b1;
	endtask : send
endmodule : asc_far_end
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: Self-checking bench of the two-channel serial block.
// Assumes: Gear clock base and divisor zero, so sixteen clocks a bit.
// Notes:   Channel zero sends to one far end, channel one hears the other.
`timescale 1ns/100ps
`default_nettype none
`include "asc_regs.svh"
module tb_top;
	logic        i_clk;
	logic        i_sys_rst;
	logic [11:0] i_addr;
	logic [7:0]  i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic        i_chan0_serial_in;
	logic        i_chan1_serial_in;
	logic [7:0]  o_rdata;
	logic        o_chan0_serial_out;
	logic        o_chan1_serial_out;
	logic        o_irq;
	logic        par0;
	logic [7:0]  b0;
	logic        p0;
	int          n0;
	logic        i_timer_output_source;
	logic [7:0]  b1;
	int          n1;
	int          mismatches;
	int          num_checks;
	asc_top DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .i_timer_output_source(i_timer_output_source), .i_chan0_serial_in(i_chan0_serial_in),
		.i_chan1_serial_in(i_chan1_serial_in), .o_rdata(o_rdata), .o_chan0_serial_out(o_chan0_serial_out),
		.o_chan1_serial_out(o_chan1_serial_out), .o_irq(o_irq));
	asc_far_end far0 (.i_clk(i_clk), .i_line(o_chan0_serial_out), .i_par_en(par0),
		.o_line(i_chan0_serial_in), .o_byte(b0), .o_par(p0), .o_count(n0));
	asc_far_end far1 (.i_clk(i_clk), .i_line(o_chan1_serial_out), .i_par_en(1'b0),
		.o_line(i_chan1_serial_in), .o_byte(b1), .o_par(), .o_count(n1));
	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_clk);
		{i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge i_clk);
		{i_rd, i_addr} <= {1'b1, a};
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : rd
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_irq(input logic exp);
		repeat (2) @(posedge i_clk);
		#1 chk("irq", {7'h00, exp}, {7'h00, o_irq});
	endtask : chk_irq
	task automatic wait_frame(input int n);
		for (int i = 0; i < 400 && n0 == n; i++) @(posedge i_clk);
		chk("frame arrived", 8'(n + 1), 8'(n0));
	endtask : wait_frame
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		logic [7:0] d;
		rd(`ASC_CH1_CTL1, d);
		chk("ch1 ctl1", 8'h00, d);
		rd(`ASC_PWR_GATE, d);
		chk("gate", 8'h00, d);
		rd(12'h100, d);
		chk("unmapped", 8'h00, d);
		wr(`ASC_PWR_GATE, 8'h03);
		wr(`ASC_CH0_CTL1, 8'h01);
		rd(`ASC_CH0_CTL1, d);
		chk("reserved", 8'h00, d);
		rd(`ASC_PWR_GATE, d);
		chk("gate on", 8'h03, d);
		$display("reset test done");
	endtask : t_reset
	task automatic t_tx;
		logic [7:0] d;
		int n;
		par0 <= 1'b1;
		n = n0;
		wr(`ASC_IRQ_MASK, 8'h01);
		wr(`ASC_CH0_CTL1, 8'h98);
		wr(`ASC_CH0_DATA, 8'ha7);
		wr(`ASC_CH0_CTL1, 8'h80);
		rd(`ASC_CH0_CTL1, d);
		chk("protected", 8'h98, d);
		wait_frame(n);
		chk("tx byte", 8'ha7, b0);
		chk("even parity", 8'h01, {7'h00, p0});
		chk_irq(1'b1);
		wr(`ASC_IRQ_STAT, 8'h01);
		chk_irq(1'b0);
		wr(`ASC_CH0_CTL1, 8'h00);
		wr(`ASC_CH0_CTL1, 8'h00);
		$display("transmit test done");
	endtask : t_tx
	task automatic t_discard;
		logic [7:0] d;
		int n;
		par0 <= 1'b0;
		n = n0;
		wr(`ASC_CH0_CTL1, 8'h80);
		wr(`ASC_CH0_DATA, 8'h5a);
		for (int i = 0; i < 100 && o_chan0_serial_out; i++) @(posedge i_clk);
		wr(`ASC_CH0_DATA, 8'h33);
		wr(`ASC_CH0_CTL1, 8'h00);
		wait_frame(n);
		chk("finished byte", 8'h5a, b0);
		repeat (300) @(posedge i_clk);
		chk("frames sent", 8'(n + 1), 8'(n0));
		rd(`ASC_CH0_STAT, d);
		chk("buffer dropped", 8'h00, d);
		$display("discard test done");
	endtask : t_discard
	task automatic t_clksel;
		logic [7:0] d;
		int n;
		n = n0;
		wr(`ASC_CH0_CTL1, 8'h82);
		wr(`ASC_CH0_DATA, 8'h3c);
		repeat (100) @(posedge i_clk);
		rd(`ASC_CH0_STAT, d);
		chk("held by timer", 8'h01, d);
		i_timer_output_source <= 1'b1;
		wait_frame(n);
		chk("timer byte", 8'h3c, b0);
		wr(`ASC_CH0_CTL1, 8'h00);
		rd(`ASC_CH0_CTL1, d);
		chk("clock select kept", 8'h02, d);
		wr(`ASC_CH0_CTL1, 8'h00);
		rd(`ASC_CH0_CTL1, d);
		chk("clock select off", 8'h00, d);
		$display("clock select test done");
	endtask : t_clksel
	task automatic t_ir;
		int n;
		int k;
		n = n0;
		k = 0;
		wr(`ASC_CH0_CTL1, 8'h84);
		wr(`ASC_CH0_DATA, 8'hff);
		for (int i = 0; i < 40 && o_chan0_serial_out; i++) @(posedge i_clk);
		while (!o_chan0_serial_out && k < 20) begin
			@(posedge i_clk);
			k++;
		end
		chk("ir pulse", `ASC_IR_PULSE, 8'(k));
		wait_frame(n);
		wr(`ASC_CH0_CTL1, 8'h00);
		wr(`ASC_CH0_CTL1, 8'h00);
		$display("infrared test done");
	endtask : t_ir
	task automatic t_rx;
		logic [7:0] d;
		int n;
		wr(`ASC_IRQ_MASK, 8'h00);
		wr(`ASC_CH1_CTL1, 8'h40);
		far1.send(8'hc3, 1'b0);
		d = 8'h00;
		for (int i = 0; i < 40 && d[2] !== 1'b1; i++) rd(`ASC_CH1_STAT, d);
		rd(`ASC_CH1_DATA, d);
		chk("rx byte", 8'hc3, d);
		chk_irq(1'b0);
		wr(`ASC_IRQ_MASK, 8'h08);
		chk_irq(1'b1);
		wr(`ASC_IRQ_STAT, 8'h08);
		chk_irq(1'b0);
		n = n1;
		wr(`ASC_CH1_CTL1, 8'h80);
		wr(`ASC_CH1_DATA, 8'h96);
		for (int i = 0; i < 400 && n1 == n; i++) @(posedge i_clk);
		chk("ch1 frames", 8'(n + 1), 8'(n1));
		chk("ch1 tx byte", 8'h96, b1);
		wr(`ASC_CH1_CTL1, 8'h00);
		$display("receive test done");
	endtask : t_rx
	task automatic t_lp;
		logic [7:0] d;
		wr(`ASC_CH0_CTL1, 8'he0);
		rd(`ASC_CH0_CTL1, d);
		chk("ctl1 set", 8'he0, d);
		wr(`ASC_LP_CTRL, 8'h01);
		rd(`ASC_CH0_CTL1, d);
		chk("low power", 8'h20, d);
		wr(`ASC_LP_CTRL, 8'h00);
		$display("low power test done");
	endtask : t_lp
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	// A hang must still reach the verdict, so the span is several times the run.
	initial begin
		repeat (10000) @(posedge i_clk);
		mismatches++;
		complete_run();
	end
	initial begin
		{i_sys_rst, i_addr, i_wdata, i_wr, i_rd, par0, i_timer_output_source} = {1'b1, 12'h000, 8'h00, 4'h0};
		mismatches = 0;
		num_checks = 0;
		repeat (12) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_reset();
		t_tx();
		t_discard();
		t_clksel();
		t_ir();
		t_rx();
		t_lp();
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
